// *** design/prs_binner.sv ***
`timescale 1ns/10ps
// Digital horizontal combining: averages 1, 2 or 3 same-colour samples
module prs_binner import prs_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample input
  input wire logic in_valid,
  input wire logic in_first,
  input wire logic in_last,
  input wire prs_kind_e in_kind,
  input wire logic [11:0] in_data,
  // Combined output
  output prs_pix_s out_pix
);

  typedef struct packed {
    logic [13:0] acc;
    logic [1:0] cnt;
    prs_pix_s pix;
  } prs_bin_s;

  prs_bin_s q;
  prs_bin_s d;
  logic [13:0] sum;
  logic [1:0] num;
  logic [30:0] prod;

  always_comb begin
    d = q;
    d.pix.valid = 1'b0;
    sum = (in_first ? 14'h0000 : q.acc) + 14'(in_data);
    num = in_first ? 2'h1 : 2'(q.cnt + 2'h1);
    prod = 31'(sum) * 31'(DIV3_MUL);
    if (in_valid) begin
      d.acc = sum;
      d.cnt = num;
      if (in_last) begin
        d.pix.valid = 1'b1;
        d.pix.kind = in_kind;
        unique case (num)
          2'h2: d.pix.data = sum[12:1];
          2'h3: d.pix.data = 12'(prod >> DIV3_SHIFT);
          default: d.pix.data = sum[11:0];
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_pix = q.pix;

endmodule : prs_binner

// *** design/prs_pedestal.sv ***
`timescale 1ns/10ps
// Final datapath stage: adds the pedestal, clipping at full scale
module prs_pedestal import prs_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stream in and offset
  input wire prs_pix_s in_pix,
  input wire logic [11:0] ped,
  // Stream out
  output prs_pix_s out_pix
);

  prs_pix_s q;
  prs_pix_s d;
  logic [12:0] sum;

  always_comb begin
    d = in_pix;
    sum = {1'b0, in_pix.data} + {1'b0, ped};
    d.data = sum[12] ? PIX_MAX : sum[11:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_pix = q;

endmodule : prs_pedestal

// *** design/prs_pkg.sv ***
package prs_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ORIENT = 8'h04;
  localparam logic [7:0] OFF_X_START = 8'h08;
  localparam logic [7:0] OFF_X_END = 8'h0C;
  localparam logic [7:0] OFF_Y_START = 8'h10;
  localparam logic [7:0] OFF_Y_END = 8'h14;
  localparam logic [7:0] OFF_STEP = 8'h18;
  localparam logic [7:0] OFF_EXPO = 8'h1C;
  localparam logic [7:0] OFF_PED = 8'h20;
  localparam logic [7:0] OFF_BAYER = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_LINE_LEN = 8'h2C;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GLOBAL = 1;
  localparam int CTRL_TRIG = 2;
  localparam int CTRL_LOCK = 3;
  localparam int CTRL_EMB = 8;
  localparam int ORIENT_COL_REV = 14;
  localparam int ORIENT_ROW_REV = 15;
  localparam int STEP_X_LSB = 0;
  localparam int STEP_Y_LSB = 4;
  localparam int STEP_ACOL = 8;
  localparam int STEP_DCOL = 9;
  localparam int STEP_AROW = 10;

  // ****************************************************
  // Reset values and counts
  // ****************************************************
  localparam logic [11:0] PED_RST = 12'h0A8;
  localparam logic [11:0] PIX_MAX = 12'hFFF;
  localparam logic [11:0] X_START_RST = 12'h006;
  localparam logic [11:0] X_END_RST = 12'h905;
  localparam logic [11:0] Y_START_RST = 12'h006;
  localparam logic [11:0] Y_END_RST = 12'h60D;
  localparam logic [3:0] INC_RST = 4'h1;
  localparam logic [15:0] EXPO_RST = 16'h0010;
  localparam logic [15:0] LINE_LEN_RST = 16'h04B4;
  localparam logic [15:0] COL_START_CYC = 16'h0004;
  localparam logic [11:0] EMB_ROWS = 12'h002;
  localparam logic [16:0] DIV3_MUL = 17'h0AAAB;
  localparam int DIV3_SHIFT = 17;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_GR_RESET = 5'b00100,
    ST_GR_EXPOSE = 5'b01000,
    ST_GR_READ = 5'b10000
  } prs_state_e;

  typedef enum logic [1:0] {
    KIND_IMAGE = 2'h0,
    KIND_EMBED = 2'h1,
    KIND_BLANK = 2'h2
  } prs_kind_e;

  typedef struct packed {
    logic run;
    logic global_mode;
    logic lock;
    logic emb_en;
    logic col_rev;
    logic row_rev;
    logic [11:0] x_start;
    logic [11:0] x_end;
    logic [11:0] y_start;
    logic [11:0] y_end;
    logic [3:0] x_inc;
    logic [3:0] y_inc;
    logic analog_col_combine_en;
    logic digital_col_combine_en;
    logic analog_row_combine_en;
    logic [15:0] expo;
    logic [11:0] ped;
    logic [15:0] line_len;
  } prs_cfg_s;

  typedef struct packed {
    logic row_read;
    logic [11:0] row_read_addr;
    logic row_reset;
    logic [11:0] row_reset_addr;
    logic col_read;
    logic [11:0] col_addr;
    logic global_reset;
    logic shutter_open;
    logic analog_col_combine_en;
    logic analog_row_combine_en;
  } prs_arr_s;

  typedef struct packed {
    logic valid;
    prs_kind_e kind;
    logic [11:0] data;
  } prs_pix_s;

  // ****************************************************
  // Shared arithmetic
  // ****************************************************
  // Outputs per line/frame: window span over the subsampling factor
  function automatic logic [11:0] prs_out_count(input logic [11:0] lo,
      input logic [11:0] hi, input logic [3:0] inc);
    logic [12:0] span;
    logic [29:0] prod;
    span = {1'b0, hi} - {1'b0, lo} + 13'h0001;
    prod = 30'(span) * 30'(DIV3_MUL);
    unique case (inc)
      4'h3: prs_out_count = span[12:1];
      4'h5: prs_out_count = 12'(prod >> DIV3_SHIFT);
      default: prs_out_count = span[11:0];
    endcase
  endfunction : prs_out_count

  // Address of output index idx; pairs advance by one plus the code
  function automatic logic [11:0] prs_line_addr(input logic [11:0] lo,
      input logic [11:0] hi, input logic [3:0] inc, input logic [11:0] idx,
      input logic rev, input logic [11:0] rev_off);
    logic [15:0] ofs;
    ofs = 16'(idx[11:1]) * (16'(inc) + 16'h0001) + 16'(idx[0]);
    if (rev) begin
      prs_line_addr = hi + rev_off - ofs[11:0];
    end else begin
      prs_line_addr = lo + ofs[11:0];
    end
  endfunction : prs_line_addr

endpackage : prs_pkg

// *** design/prs_readout_seq.sv ***
`timescale 1ns/10ps
// Function
// - Add 12-bit pedestal last, reset 168
// - Pedestal writable only when lock is 0
// - Rolling shutter: equal reset-to-read per row
// - Exposure change applies whole frames only
// - Global reset: one frame, shutter ends exposure
// - Column reverse reads from end+1 to start+1
// - Column reverse flips reported Bayer order
// - Row reverse reads from end to start
// - Row reverse flips reported Bayer order
// - Horizontal binning of 2 or 3 pixels
// - Vertical binning: code 3 plus row combine
// - Skip 2x/3x; row skip shortens frame
// - Addresses step by two, Gr-R first
// - Advance one plus code after each pair
// - Code 1 reads consecutive pairs
// - Column code selects skip or binning
// - Modes use 2x2 or 3x3 subsampling
// - Two embedded rows, else two blank rows
module prs_readout_seq import prs_pkg::*; (
  // APB register port
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel array side
  output prs_arr_s arr_cmd,
  input wire logic [11:0] arr_pix,
  // External mechanical shutter
  input wire logic shutter_closed,
  // Pixel stream to host
  output prs_pix_s pix_out,
  output logic line_start,
  output logic frame_start
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    prs_state_e state;
    prs_cfg_s cfg;
    prs_cfg_s sh;
    logic trig;
    logic [11:0] slot;
    logic [15:0] cyc;
    logic [11:0] col;
    logic [1:0] sub;
    logic [11:0] nrows;
    logic [11:0] ncols;
    logic [15:0] e_cur;
    logic [15:0] e_next;
    logic [15:0] fcnt;
    logic [31:0] prdata;
    prs_arr_s arr;
    logic sync1;
    logic sync2;
    logic pd_vld;
    logic pd_first;
    logic pd_last;
    prs_kind_e pd_kind;
    logic line_start;
    logic frame_start;
  } prs_seq_s;

  prs_seq_s q;
  prs_seq_s d;

  logic wr_en;
  logic addr_ok;
  logic new_frame;
  logic [11:0] g_nrows;
  logic [15:0] g_slots;
  logic [15:0] g_expo;
  logic [15:0] slots;
  logic [17:0] k_cur;
  logic [17:0] k_nxt;
  logic [1:0] fac;
  logic [11:0] bin_data;
  prs_pix_s bin_pix;
  prs_kind_e slot_kind;

  // ****************************************************
  // Register access
  // ****************************************************
  function automatic logic [31:0] rd_word(input logic [7:0] a,
      input prs_seq_s s);
    logic [31:0] w;
    w = '0;
    unique case (a)
      OFF_CTRL: begin
        w[CTRL_RUN] = s.cfg.run;
        w[CTRL_GLOBAL] = s.cfg.global_mode;
        w[CTRL_TRIG] = s.trig;
        w[CTRL_LOCK] = s.cfg.lock;
        w[CTRL_EMB] = s.cfg.emb_en;
      end
      OFF_ORIENT: begin
        w[ORIENT_COL_REV] = s.cfg.col_rev;
        w[ORIENT_ROW_REV] = s.cfg.row_rev;
      end
      OFF_X_START: w[11:0] = s.cfg.x_start;
      OFF_X_END: w[11:0] = s.cfg.x_end;
      OFF_Y_START: w[11:0] = s.cfg.y_start;
      OFF_Y_END: w[11:0] = s.cfg.y_end;
      OFF_STEP: begin
        w[STEP_X_LSB +: 4] = s.cfg.x_inc;
        w[STEP_Y_LSB +: 4] = s.cfg.y_inc;
        w[STEP_ACOL] = s.cfg.analog_col_combine_en;
        w[STEP_DCOL] = s.cfg.digital_col_combine_en;
        w[STEP_AROW] = s.cfg.analog_row_combine_en;
      end
      OFF_EXPO: w[15:0] = s.cfg.expo;
      OFF_PED: w[11:0] = s.cfg.ped;
      // Order of the frame on the output, not of the pending settings
      OFF_BAYER: w[1:0] = {s.sh.row_rev, s.sh.col_rev};
      OFF_STATUS: w = {s.fcnt, 11'h000, s.state};
      OFF_LINE_LEN: w[15:0] = s.cfg.line_len;
      default: w = '0;
    endcase
    return w;
  endfunction : rd_word

  always_comb begin
    unique case (paddr)
      OFF_CTRL, OFF_ORIENT, OFF_X_START, OFF_X_END, OFF_Y_START,
      OFF_Y_END, OFF_STEP, OFF_EXPO, OFF_PED, OFF_BAYER, OFF_STATUS,
      OFF_LINE_LEN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign wr_en = psel && penable && pwrite && addr_ok;

  // ****************************************************
  // Geometry of the frame about to start
  // ****************************************************
  assign g_nrows = prs_out_count(q.cfg.y_start, q.cfg.y_end,
      q.cfg.y_inc);
  assign g_slots = 16'(g_nrows) + 16'(EMB_ROWS);
  assign slots = 16'(q.nrows) + 16'(EMB_ROWS);
  // A frame cannot hold more exposure than it has rows
  assign g_expo = (q.cfg.expo == 16'h0000) ? 16'h0001 :
      ((q.cfg.expo > g_slots) ? g_slots : q.cfg.expo);
  assign k_cur = 18'(q.slot) + 18'(q.e_cur) - 18'(EMB_ROWS);
  assign k_nxt = 18'(q.slot) + 18'(q.e_next) - 18'(EMB_ROWS) - 18'(slots);
  assign fac = q.sh.digital_col_combine_en ?
      2'((q.sh.x_inc + 4'h1) >> 1) : 2'h1;
  assign slot_kind = (q.slot >= EMB_ROWS) ? KIND_IMAGE :
      (q.sh.emb_en ? KIND_EMBED : KIND_BLANK);

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    d = q;
    new_frame = 1'b0;
    d.arr.row_read = 1'b0;
    d.arr.row_reset = 1'b0;
    d.arr.col_read = 1'b0;
    d.pd_vld = 1'b0;
    d.line_start = 1'b0;
    d.frame_start = 1'b0;
    d.sync1 = shutter_closed;
    d.sync2 = q.sync1;
    d.arr.analog_col_combine_en = q.sh.analog_col_combine_en;
    d.arr.analog_row_combine_en = q.sh.analog_row_combine_en &&
        (q.sh.y_inc == 4'h3);

    unique case (q.state)
      ST_IDLE: begin
        if (q.cfg.global_mode && q.trig) begin
          d.trig = 1'b0;
          d.sh = q.cfg;
          d.cyc = '0;
          d.state = ST_GR_RESET;
        end else if (q.cfg.run && !q.cfg.global_mode) begin
          new_frame = 1'b1;
          d.state = ST_RUN;
        end
      end
      ST_GR_RESET: begin
        d.arr.global_reset = 1'b1;
        d.cyc = q.cyc + 16'h0001;
        if (q.cyc >= q.sh.line_len - 16'h0001) begin
          d.arr.global_reset = 1'b0;
          d.arr.shutter_open = 1'b1;
          d.state = ST_GR_EXPOSE;
        end
      end
      ST_GR_EXPOSE: begin
        // Exposure ends when the shutter reports closed, not on a count
        if (q.sync2) begin
          d.arr.shutter_open = 1'b0;
          new_frame = 1'b1;
          d.state = ST_GR_READ;
        end
      end
      ST_RUN, ST_GR_READ: begin
        d.cyc = q.cyc + 16'h0001;
        if (q.cyc == 16'h0000) begin
          d.line_start = 1'b1;
          if (q.slot >= EMB_ROWS) begin
            d.arr.row_read = 1'b1;
            d.arr.row_read_addr = prs_line_addr(q.sh.y_start, q.sh.y_end,
                q.sh.y_inc, q.slot - EMB_ROWS, q.sh.row_rev,
                12'h000);
          end
        end
        // In ST_RUN each row is reset a fixed number of slots before its read; ST_GR_READ issues no row resets
        if (q.state == ST_RUN && q.cyc == 16'h0001 &&
            !k_cur[17] && k_cur < 18'(q.nrows)) begin
          d.arr.row_reset = 1'b1;
          d.arr.row_reset_addr = prs_line_addr(q.sh.y_start, q.sh.y_end,
              q.sh.y_inc, k_cur[11:0], q.sh.row_rev, 12'h000);
        end
        // Rows of the next frame use the exposure latched for that frame
        if (q.state == ST_RUN && q.cyc == 16'h0002 &&
            !k_nxt[17] && k_nxt < 18'(q.nrows)) begin
          d.arr.row_reset = 1'b1;
          d.arr.row_reset_addr = prs_line_addr(q.sh.y_start, q.sh.y_end,
              q.sh.y_inc, k_nxt[11:0], q.sh.row_rev, 12'h000);
        end
        // Columns start at COL_START_CYC for any code and the line ends at line_len, so the row period holds
        if (q.cyc >= COL_START_CYC && q.col < q.ncols) begin
          d.arr.col_read = (slot_kind == KIND_IMAGE);
          d.arr.col_addr = prs_line_addr(q.sh.x_start, q.sh.x_end,
              q.sh.x_inc, q.col, q.sh.col_rev, 12'h001) +
              {9'h000, q.sub, 1'b0};
          d.pd_vld = 1'b1;
          d.pd_first = (q.sub == 2'h0);
          d.pd_last = (q.sub == fac - 2'h1);
          d.pd_kind = slot_kind;
          if (q.sub == fac - 2'h1) begin
            d.sub = 2'h0;
            d.col = q.col + 12'h001;
          end else begin
            d.sub = q.sub + 2'h1;
          end
        end
        if (q.cyc >= q.sh.line_len - 16'h0001) begin
          d.cyc = '0;
          d.col = '0;
          d.sub = '0;
          if (16'(q.slot) >= slots - 16'h0001) begin
            if (q.state == ST_RUN && q.cfg.run && !q.cfg.global_mode) begin
              new_frame = 1'b1;
            end else begin
              d.state = ST_IDLE;
            end
          end else begin
            d.slot = q.slot + 12'h001;
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase

    // Settings only change on a frame boundary
    if (new_frame) begin
      d.sh = q.cfg;
      d.nrows = g_nrows;
      d.ncols = prs_out_count(q.cfg.x_start, q.cfg.x_end, q.cfg.x_inc);
      d.e_cur = (q.state == ST_RUN) ? q.e_next : g_expo;
      d.e_next = g_expo;
      d.slot = '0;
      d.cyc = '0;
      d.col = '0;
      d.sub = '0;
      d.fcnt = q.fcnt + 16'h0001;
      d.frame_start = 1'b1;
    end

    // APB after the sequencer so that a write of the trigger wins
    if (psel && !penable) begin
      d.prdata = rd_word(paddr, q);
    end
    if (wr_en) begin
      unique case (paddr)
        OFF_CTRL: begin
          d.cfg.run = pwdata[CTRL_RUN];
          d.cfg.global_mode = pwdata[CTRL_GLOBAL];
          d.cfg.lock = pwdata[CTRL_LOCK];
          d.cfg.emb_en = pwdata[CTRL_EMB];
          d.trig = d.trig || pwdata[CTRL_TRIG];
        end
        OFF_ORIENT: begin
          d.cfg.col_rev = pwdata[ORIENT_COL_REV];
          d.cfg.row_rev = pwdata[ORIENT_ROW_REV];
        end
        OFF_X_START: d.cfg.x_start = pwdata[11:0];
        OFF_X_END: d.cfg.x_end = pwdata[11:0];
        OFF_Y_START: d.cfg.y_start = pwdata[11:0];
        OFF_Y_END: d.cfg.y_end = pwdata[11:0];
        OFF_STEP: begin
          d.cfg.x_inc = pwdata[STEP_X_LSB +: 4];
          d.cfg.y_inc = pwdata[STEP_Y_LSB +: 4];
          d.cfg.analog_col_combine_en = pwdata[STEP_ACOL];
          d.cfg.digital_col_combine_en = pwdata[STEP_DCOL];
          d.cfg.analog_row_combine_en = pwdata[STEP_AROW];
        end
        OFF_EXPO: d.cfg.expo = pwdata[15:0];
        OFF_PED: begin
          if (!q.cfg.lock) begin
            d.cfg.ped = pwdata[11:0];
          end
        end
        OFF_LINE_LEN: d.cfg.line_len = pwdata[15:0];
        default: d.cfg = q.cfg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.cfg.lock <= 1'b1;
      q.cfg.emb_en <= 1'b1;
      q.cfg.ped <= PED_RST;
      q.cfg.x_start <= X_START_RST;
      q.cfg.x_end <= X_END_RST;
      q.cfg.y_start <= Y_START_RST;
      q.cfg.y_end <= Y_END_RST;
      q.cfg.x_inc <= INC_RST;
      q.cfg.y_inc <= INC_RST;
      q.cfg.expo <= EXPO_RST;
      q.cfg.line_len <= LINE_LEN_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************
  // Pixel datapath
  // ****************************************************
  // Array data stands in the cycle of the column strobe
  assign bin_data = (q.pd_kind == KIND_IMAGE) ? arr_pix :
      ((q.pd_kind == KIND_EMBED) ? q.fcnt[11:0] : 12'h000);

  prs_binner u_binner (.pclk(pclk), .presetn(presetn), .in_valid(q.pd_vld),
    .in_first(q.pd_first), .in_last(q.pd_last), .in_kind(q.pd_kind),
    .in_data(bin_data), .out_pix(bin_pix));

  prs_pedestal u_pedestal (.pclk(pclk), .presetn(presetn), .in_pix(bin_pix),
    .ped((bin_pix.kind == KIND_IMAGE) ? q.sh.ped : 12'h000),
    .out_pix(pix_out));

  assign arr_cmd = q.arr;
  assign prdata = q.prdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign line_start = q.line_start;
  assign frame_start = q.frame_start;

endmodule : prs_readout_seq

// *** testbench/prs_array_model.sv ***
`timescale 1ns/10ps
module prs_array_model import prs_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Array commands and samples
  input wire prs_arr_s arr_cmd,
  output logic [11:0] arr_pix
);
  // Sample equals its column and stands while the strobe does; otherwise
  // the line shows the inverse, so a sample taken late is caught
  always_comb begin
    if (presetn && arr_cmd.col_read) begin
      arr_pix = arr_cmd.col_addr;
    end else begin
      arr_pix = ~arr_cmd.col_addr;
    end
  end
endmodule : prs_array_model

// *** testbench/prs_readout_seq_asserts.sv ***
`timescale 1ns/10ps
module prs_readout_seq_asserts import prs_pkg::*; (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Array, shutter and stream
  input wire prs_arr_s arr_cmd,
  input wire logic shutter_closed,
  input wire prs_pix_s pix_out,
  input wire logic line_start,
  input wire logic frame_start
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************************
  // Checks
  // ****************************************************
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_unmap_err: assert property (psel && penable && paddr > 8'h2C
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  a_row_read: assert property (
    arr_cmd.row_read |-> line_start ##1 !arr_cmd.row_read)
    else $error("row read off slot start");
  a_gr_excl: assert property (
    arr_cmd.global_reset |-> !arr_cmd.shutter_open && !arr_cmd.row_read)
    else $error("global reset overlaps exposure");
  a_shut_close: assert property (
    arr_cmd.shutter_open && shutter_closed |-> ##[1:4] !arr_cmd.shutter_open)
    else $error("shutter close ignored");
  a_expose_quiet: assert property (
    arr_cmd.shutter_open |-> !arr_cmd.row_reset && !pix_out.valid)
    else $error("activity during exposure");
  a_pix_latency: assert property (
    pix_out.valid && pix_out.kind == KIND_IMAGE
    |-> $past(arr_cmd.col_read, 2)) else $error("pixel without sample");
  a_vert_rows: assert property (
    frame_start |=> !arr_cmd.col_read [*8])
    else $error("no extra rows at frame start");
endmodule : prs_readout_seq_asserts

bind prs_readout_seq prs_readout_seq_asserts u_chk (.pclk, .presetn,
  .psel, .penable, .paddr, .prdata, .pready, .pslverr, .arr_cmd,
  .shutter_closed, .pix_out, .line_start, .frame_start);

// *** testbench/prs_readout_seq_tb_top.sv ***
`timescale 1ns/10ps
module prs_readout_seq_tb_top import prs_pkg::*; ;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] v;
  } prs_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, line_start, frame_start, err;
  logic shutter_closed = 1'b0;
  logic seen_gr = 1'b0;
  logic [11:0] arr_pix;
  prs_arr_s arr_cmd;
  prs_pix_s pix_out;
  int mismatches = 0;
  int comparisons = 0;
  logic [11:0] colq[$], rowq[$], pixq[$];
  prs_row_s rows[12] = '{'{OFF_CTRL, 32'h108}, '{OFF_ORIENT, 32'h0},
    '{OFF_X_START, 32'h6}, '{OFF_X_END, 32'h905}, '{OFF_Y_START, 32'h6},
    '{OFF_Y_END, 32'h60D}, '{OFF_STEP, 32'h11}, '{OFF_EXPO, 32'h10},
    '{OFF_PED, 32'hA8}, '{OFF_BAYER, 32'h0}, '{OFF_STATUS, 32'h1},
    '{OFF_LINE_LEN, 32'h4B4}};

  always #12.5 pclk = ~pclk;

  prs_readout_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arr_cmd(arr_cmd), .arr_pix(arr_pix), .shutter_closed(shutter_closed),
    .pix_out(pix_out), .line_start(line_start), .frame_start(frame_start));
  prs_array_model u_arr (.pclk(pclk), .presetn(presetn),
    .arr_cmd(arr_cmd), .arr_pix(arr_pix));

  // ****************************************************
  // Monitor and shutter
  // ****************************************************
  // Mechanical shutter closes one cycle after it is told to open
  always @(posedge pclk) begin
    shutter_closed <= arr_cmd.shutter_open;
    if (arr_cmd.shutter_open) seen_gr <= 1'b1;
    if (arr_cmd.col_read) colq.push_back(arr_cmd.col_addr);
    if (arr_cmd.row_read) rowq.push_back(arr_cmd.row_read_addr);
    if (pix_out.valid && pix_out.kind == KIND_IMAGE)
      pixq.push_back(pix_out.data);
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[0]) break;
    end
  endtask : wait_idle

  // Address of output i: pairs advance by one plus the step code
  function automatic logic [11:0] ea(input logic [11:0] hi, input int c,
      input int i, input logic rv, input logic [11:0] ro);
    int o;
    o = (i / 2) * (c + 1) + (i % 2);
    return rv ? hi + ro - 12'(o) : 12'h006 + 12'(o);
  endfunction : ea

  // One rolling frame, then addresses, data and reported order
  task automatic frame(input logic [15:0] ori, input logic [15:0] step,
      input logic [11:0] xe, input logic [11:0] ye, input int xc,
      input int yc, input int nc, input int nr, input int fb);
    logic [12:0] s;
    logic [11:0] a;
    apb(1'b1, OFF_ORIENT, 32'(ori));
    apb(1'b1, OFF_STEP, 32'(step));
    apb(1'b1, OFF_X_END, 32'(xe));
    apb(1'b1, OFF_Y_END, 32'(ye));
    colq.delete();
    rowq.delete();
    pixq.delete();
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0);
    wait_idle();
    chk(colq.size(), nc * nr * fb);
    chk(rowq.size(), nr);
    for (int i = 0; i < nc; i++) begin
      a = ea(xe, xc, i, ori[14], 12'h001);
      // Averaging fb samples a, a+2, ... gives a+fb-1
      s = 13'(a) + 13'(fb - 1) + 13'h0FF0;
      chk(colq[i * fb], a);
      chk(pixq[i], s[12] ? 12'hFFF : s[11:0]);
    end
    for (int i = 0; i < nr; i++) begin
      chk(rowq[i], ea(ye, yc, i, ori[15], 12'h000));
    end
    apb(1'b0, OFF_BAYER, 32'h0);
    chk(rd, 32'(ori[15:14]));
  endtask : frame

  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].v);
    end
    apb(1'b1, OFF_PED, 32'h10);
    apb(1'b0, OFF_PED, 32'h0);
    chk(rd, 32'hA8);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_PED, 32'hFF0);
    apb(1'b0, OFF_PED, 32'h0);
    chk(rd, 32'hFF0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, OFF_LINE_LEN, 32'h10);
    // Window starts stay 6 and spans over the factor stay even
    frame(16'h0000, 16'h0011, 12'h00D, 12'h009, 1, 1, 8, 4, 1);
    frame(16'hC000, 16'h0011, 12'h00D, 12'h009, 1, 1, 8, 4, 1);
    frame(16'h0000, 16'h0533, 12'h015, 12'h00D, 3, 3, 8, 4, 1);
    chk(arr_cmd.analog_row_combine_en, 1'b1);
    chk(arr_cmd.analog_col_combine_en, 1'b1);
    frame(16'h0000, 16'h0215, 12'h011, 12'h009, 5, 1, 4, 4, 3);
    frame(16'h0000, 16'h0015, 12'h011, 12'h009, 5, 1, 4, 4, 1);
    rowq.delete();
    pixq.delete();
    apb(1'b1, OFF_CTRL, 32'h6);
    wait_idle();
    chk(seen_gr, 1'b1);
    chk(rowq.size(), 4);
    chk(pixq.size(), 16);
    complete_run();
  end
endmodule : prs_readout_seq_tb_top
